// ===== pkg/fine_dac_pkg.sv
// Constants shared by the fine DAC override register bank
package fine_dac_pkg;

  // Register layout
  localparam int unsigned REG_W      = 8;
  localparam int unsigned OVR_BIT    = 7;
  localparam int unsigned UNUSED_BIT = 6;
  localparam int unsigned CODE_LSB   = 0;
  localparam int unsigned CODE_W     = 6;
  localparam int unsigned EXP_W      = 3;
  localparam int unsigned NUM_REGS   = 6;
  localparam int unsigned IDX_W      = 8;
  localparam int unsigned ADDR_W     = 32;

  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [REG_W-1:0] WR_MASK   = 8'hBF;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CH1_EXP6    = 8'h31;
  localparam logic [IDX_W-1:0] IDX_CH2_EXP1    = 8'h32;
  localparam logic [IDX_W-1:0] IDX_CH2_EXP2    = 8'h33;
  localparam logic [IDX_W-1:0] IDX_CH2_EXP3    = 8'h34;
  localparam logic [IDX_W-1:0] IDX_CH2_EXP4    = 8'h35;
  localparam logic [IDX_W-1:0] IDX_CH2_EXP5    = 8'h36;
  localparam logic [IDX_W-1:0] IDX_CH1_APPLIED = 8'h38;
  localparam logic [IDX_W-1:0] IDX_CH2_APPLIED = 8'h39;

  // Slot order of the register cells
  localparam logic [IDX_W-1:0] REG_IDX [NUM_REGS] = '{
    IDX_CH1_EXP6, IDX_CH2_EXP1, IDX_CH2_EXP2,
    IDX_CH2_EXP3, IDX_CH2_EXP4, IDX_CH2_EXP5
  };
  localparam int unsigned SLOT_CH1      = 0;
  localparam int unsigned SLOT_CH2_BASE = 1;
  localparam int unsigned CH2_NUM_EXP   = 5;

  // Exposures served by each channel
  localparam logic [EXP_W-1:0] CH1_FIRST_EXP = 3'h6;
  localparam logic [EXP_W-1:0] CH2_FIRST_EXP = 3'h1;

  // Applied-status register fields
  localparam int unsigned STAT_ACTIVE_BIT = 7;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_BUSY   = 2'h1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Data-phase state of the bus slave
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b001,
    PH_WRITE = 3'b010,
    PH_READ  = 3'b100
  } bus_phase_t;

endpackage : fine_dac_pkg

// ===== rtl/fine_dac_reg_cell.sv
// One override register: enable bit plus six-bit code
module fine_dac_reg_cell
  import fine_dac_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // Write port
  input  wire logic             wr_en_in,
  input  wire logic [REG_W-1:0] wdata_in,
  // Stored value
  output logic      [REG_W-1:0] q_out
);
  logic [REG_W-1:0] value_r;

  // Unused bit never stores, so it always reads zero
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      value_r <= REG_RESET;
    end else if (wr_en_in) begin
      value_r <= wdata_in & WR_MASK;
    end
  end

  assign q_out = value_r;

endmodule : fine_dac_reg_cell

// ===== rtl/fine_code_select.sv
// Per-channel choice between the on-chip and the software fine code
module fine_code_select
  import fine_dac_pkg::*;
#(
  parameter int unsigned      NUM_EXP   = 1,
  parameter logic [EXP_W-1:0] FIRST_EXP = 3'h1
) (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      arst_n_in,
  // Conversion control from the ADC sequencer
  input  wire logic                      conv_start_in,
  input  wire logic [EXP_W-1:0]          exposure_in,
  input  wire logic [CODE_W-1:0]         auto_code_in,
  // Software settings, one slot per served exposure
  input  wire logic [NUM_EXP-1:0]        ovr_vec_in,
  input  wire logic [NUM_EXP*CODE_W-1:0] code_vec_in,
  // Code used by the conversion
  output logic      [CODE_W-1:0]         dac_code_out,
  output logic                           sw_active_out
);
  logic [CODE_W-1:0] code_nxt;
  logic              active_nxt;
  logic [CODE_W-1:0] code_r;
  logic              active_r;

  always_comb begin
    code_nxt   = auto_code_in;
    active_nxt = 1'b0;
    for (int i = 0; i < NUM_EXP; i++) begin
      if (exposure_in == FIRST_EXP + EXP_W'(i) && ovr_vec_in[i]) begin
        code_nxt   = code_vec_in[i*CODE_W +: CODE_W];
        active_nxt = 1'b1;
      end
    end
  end

  // Captured at conversion start so a register write during a
  // conversion cannot disturb the subranging mid-way
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      code_r   <= '0;
      active_r <= 1'b0;
    end else if (conv_start_in) begin
      code_r   <= code_nxt;
      active_r <= active_nxt;
    end
  end

  assign dac_code_out  = code_r;
  assign sw_active_out = active_r;

endmodule : fine_code_select

// ===== rtl/fine_dac_override_regs.sv
// Fine DAC override register bank with AHB-Lite access
// Functional notes
// - Register 0x31 holds override in bit 7, unused bit 6 and a code in 5:0 for channel 1 exposure 6.
// - With the channel 1 exposure 6 override set, its code drives the fine DAC in that exposure.
// - With that override clear, the on-chip code is used and the stored code has no effect.
// - Register 0x32 holds override and code for channel 2 exposure 1.
// - Register 0x33 holds override and code for channel 2 exposure 2.
// - Register 0x34 holds override and code for channel 2 exposure 3.
// - Register 0x35 holds override and code for channel 2 exposure 4.
// - Register 0x36 holds override and code for channel 2 exposure 5.
// - A set channel 2 override makes its code drive that exposure's fine DAC.
// - A clear channel 2 override leaves the choice to on-chip logic.
module fine_dac_override_regs
  import fine_dac_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      arst_n_in,
  // AHB-Lite slave
  input  wire logic                      hsel_in,
  input  wire logic [ADDR_W-1:0]         haddr_in,
  input  wire logic [1:0]                htrans_in,
  input  wire logic                      hwrite_in,
  input  wire logic [2:0]                hsize_in,
  input  wire logic [31:0]               hwdata_in,
  input  wire logic                      hready_in,
  output logic      [31:0]               hrdata_out,
  output logic                           hreadyout_out,
  output logic                           hresp_out,
  // First readout channel conversion
  input  wire logic                      ch1_conv_start_in,
  input  wire logic [EXP_W-1:0]          ch1_exposure_in,
  input  wire logic [CODE_W-1:0]         ch1_auto_code_in,
  output logic      [CODE_W-1:0]         ch1_dac_code_out,
  output logic                           ch1_sw_active_out,
  // Second readout channel conversion
  input  wire logic                      ch2_conv_start_in,
  input  wire logic [EXP_W-1:0]          ch2_exposure_in,
  input  wire logic [CODE_W-1:0]         ch2_auto_code_in,
  output logic      [CODE_W-1:0]         ch2_dac_code_out,
  output logic                           ch2_sw_active_out
);
  import fine_dac_pkg::*;

  // Address-phase decode
  logic                   addr_valid;
  logic                   lane_ok;
  logic                   in_range;
  logic                   take_xfer;
  logic [IDX_W-1:0]       addr_idx;

  // Data-phase state
  bus_phase_t             phase_r;
  bus_phase_t             phase_nxt;
  logic [IDX_W-1:0]       wr_idx_r;
  logic                   wr_lane_ok_r;

  // Register cells and their write strobes
  logic [NUM_REGS-1:0]    cell_wr;
  logic [REG_W-1:0]       cell_q [NUM_REGS];
  logic [REG_W-1:0]       wr_byte;

  // Read path
  logic [REG_W-1:0]       rd_byte;
  logic [REG_W-1:0]       rd_byte_fwd;
  logic [31:0]            hrdata_r;

  // Channel feeds
  logic [CH2_NUM_EXP-1:0]        ch2_ovr_vec;
  logic [CH2_NUM_EXP*CODE_W-1:0] ch2_code_vec;
  logic [REG_W-1:0]              ch1_status;
  logic [REG_W-1:0]              ch2_status;

  // Fields of the override registers, named by what they steer
  logic                          ch1_exp6_override;
  logic [CODE_W-1:0]             ch1_exp6_code;
  logic                          ch2_exp1_override;
  logic [CODE_W-1:0]             ch2_exp1_code;
  logic                          ch2_exp2_override;
  logic [CODE_W-1:0]             ch2_exp2_code;
  logic                          ch2_exp3_override;
  logic [CODE_W-1:0]             ch2_exp3_code;
  logic                          ch2_exp4_override;
  logic [CODE_W-1:0]             ch2_exp4_code;
  logic                          ch2_exp5_override;
  logic [CODE_W-1:0]             ch2_exp5_code;

  // Address phase
  assign addr_valid = hsel_in && hready_in &&
                      (htrans_in == HTRANS_NONSEQ ||
                       htrans_in == HTRANS_SEQ);

  assign in_range = (haddr_in[ADDR_W-1:IDX_W+2] == '0);
  assign addr_idx = haddr_in[IDX_W+1:2];

  // Each register is the low byte of its word, so only accesses
  // that touch byte lane 0 carry data for it
  assign lane_ok  = in_range && (haddr_in[1:0] == 2'h0) &&
                    (hsize_in <= HSIZE_WORD);

  assign take_xfer = addr_valid;

  always_comb begin
    phase_nxt = PH_IDLE;
    case (phase_r)
      PH_IDLE: begin
        if (take_xfer && hwrite_in) begin
          phase_nxt = PH_WRITE;
        end else if (take_xfer) begin
          phase_nxt = PH_READ;
        end else begin
          phase_nxt = PH_IDLE;
        end
      end
      // The next address phase overlaps this data phase, so a new
      // transfer may start here with no idle cycle between
      PH_WRITE: begin
        if (take_xfer && hwrite_in) begin
          phase_nxt = PH_WRITE;
        end else if (take_xfer) begin
          phase_nxt = PH_READ;
        end else begin
          phase_nxt = PH_IDLE;
        end
      end
      PH_READ: begin
        if (take_xfer && hwrite_in) begin
          phase_nxt = PH_WRITE;
        end else if (take_xfer) begin
          phase_nxt = PH_READ;
        end else begin
          phase_nxt = PH_IDLE;
        end
      end
      default: begin
        phase_nxt = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_r <= PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_idx_r     <= '0;
      wr_lane_ok_r <= 1'b0;
    end else if (take_xfer && hwrite_in) begin
      wr_idx_r     <= addr_idx;
      wr_lane_ok_r <= lane_ok;
    end
  end

  // Write data phase into the register cells
  assign wr_byte = hwdata_in[REG_W-1:0];

  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_cell
      assign cell_wr[g] = (phase_r == PH_WRITE) && wr_lane_ok_r &&
                          (wr_idx_r == REG_IDX[g]);

      fine_dac_reg_cell u_cell (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .wr_en_in  (cell_wr[g]),
        .wdata_in  (wr_byte),
        .q_out     (cell_q[g])
      );
    end
  endgenerate

  // Field split of each cell
  assign ch1_exp6_override = cell_q[SLOT_CH1][OVR_BIT];
  assign ch1_exp6_code     = cell_q[SLOT_CH1][CODE_LSB +: CODE_W];
  assign ch2_exp1_override = cell_q[SLOT_CH2_BASE][OVR_BIT];
  assign ch2_exp1_code     = cell_q[SLOT_CH2_BASE][CODE_LSB +: CODE_W];
  assign ch2_exp2_override = cell_q[SLOT_CH2_BASE+1][OVR_BIT];
  assign ch2_exp2_code     = cell_q[SLOT_CH2_BASE+1][CODE_LSB +: CODE_W];
  assign ch2_exp3_override = cell_q[SLOT_CH2_BASE+2][OVR_BIT];
  assign ch2_exp3_code     = cell_q[SLOT_CH2_BASE+2][CODE_LSB +: CODE_W];
  assign ch2_exp4_override = cell_q[SLOT_CH2_BASE+3][OVR_BIT];
  assign ch2_exp4_code     = cell_q[SLOT_CH2_BASE+3][CODE_LSB +: CODE_W];
  assign ch2_exp5_override = cell_q[SLOT_CH2_BASE+4][OVR_BIT];
  assign ch2_exp5_code     = cell_q[SLOT_CH2_BASE+4][CODE_LSB +: CODE_W];

  // Read path: data are sampled at the address-phase edge
  // The unused bit is rebuilt as zero so it can never leak out
  always_comb begin
    if (!lane_ok) begin
      rd_byte = '0;
    end else if (addr_idx == IDX_CH1_EXP6) begin
      rd_byte = {ch1_exp6_override, 1'b0, ch1_exp6_code};
    end else if (addr_idx == IDX_CH2_EXP1) begin
      rd_byte = {ch2_exp1_override, 1'b0, ch2_exp1_code};
    end else if (addr_idx == IDX_CH2_EXP2) begin
      rd_byte = {ch2_exp2_override, 1'b0, ch2_exp2_code};
    end else if (addr_idx == IDX_CH2_EXP3) begin
      rd_byte = {ch2_exp3_override, 1'b0, ch2_exp3_code};
    end else if (addr_idx == IDX_CH2_EXP4) begin
      rd_byte = {ch2_exp4_override, 1'b0, ch2_exp4_code};
    end else if (addr_idx == IDX_CH2_EXP5) begin
      rd_byte = {ch2_exp5_override, 1'b0, ch2_exp5_code};
    end else if (addr_idx == IDX_CH1_APPLIED) begin
      rd_byte = ch1_status;
    end else if (addr_idx == IDX_CH2_APPLIED) begin
      rd_byte = ch2_status;
    end else begin
      rd_byte = '0;
    end
  end

  // A read right behind a write to the same register would
  // otherwise see the old value, since the cell updates one edge late
  always_comb begin
    rd_byte_fwd = rd_byte;
    if (phase_r == PH_WRITE && wr_lane_ok_r && lane_ok &&
        wr_idx_r == addr_idx) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (addr_idx == REG_IDX[i]) begin
          rd_byte_fwd = wr_byte & WR_MASK;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hrdata_r <= '0;
    end else if (take_xfer && !hwrite_in) begin
      hrdata_r <= {24'h000000, rd_byte_fwd};
    end else if (take_xfer) begin
      hrdata_r <= '0;
    end
  end

  assign hrdata_out    = hrdata_r;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = HRESP_OKAY;

  // Code selection per readout channel
  generate
    for (genvar e = 0; e < CH2_NUM_EXP; e++) begin : g_ch2
      assign ch2_ovr_vec[e] = cell_q[SLOT_CH2_BASE+e][OVR_BIT];
      assign ch2_code_vec[e*CODE_W +: CODE_W] =
        cell_q[SLOT_CH2_BASE+e][CODE_LSB +: CODE_W];
    end
  endgenerate

  fine_code_select #(
    .NUM_EXP   (1),
    .FIRST_EXP (CH1_FIRST_EXP)
  ) u_ch1_select (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .conv_start_in (ch1_conv_start_in),
    .exposure_in   (ch1_exposure_in),
    .auto_code_in  (ch1_auto_code_in),
    .ovr_vec_in    (ch1_exp6_override),
    .code_vec_in   (ch1_exp6_code),
    .dac_code_out  (ch1_dac_code_out),
    .sw_active_out (ch1_sw_active_out)
  );

  fine_code_select #(
    .NUM_EXP   (CH2_NUM_EXP),
    .FIRST_EXP (CH2_FIRST_EXP)
  ) u_ch2_select (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .conv_start_in (ch2_conv_start_in),
    .exposure_in   (ch2_exposure_in),
    .auto_code_in  (ch2_auto_code_in),
    .ovr_vec_in    (ch2_ovr_vec),
    .code_vec_in   (ch2_code_vec),
    .dac_code_out  (ch2_dac_code_out),
    .sw_active_out (ch2_sw_active_out)
  );

  // Software can see which code the last conversion really used
  assign ch1_status = {ch1_sw_active_out, 1'b0, ch1_dac_code_out};
  assign ch2_status = {ch2_sw_active_out, 1'b0, ch2_dac_code_out};

endmodule : fine_dac_override_regs

// ===== sim/fine_dac_assertions.sv
// Port-level checks of the fine DAC override register bank
module fine_dac_checker
  import fine_dac_pkg::*;
(
  // Clock and reset
  input wire logic              clk_in,
  input wire logic              arst_n_in,
  // Bus answer
  input wire logic [31:0]       hrdata_out,
  input wire logic              hreadyout_out,
  input wire logic              hresp_out,
  // First channel
  input wire logic              ch1_conv_start_in,
  input wire logic [EXP_W-1:0]  ch1_exposure_in,
  input wire logic [CODE_W-1:0] ch1_auto_code_in,
  input wire logic [CODE_W-1:0] ch1_dac_code_out,
  input wire logic              ch1_sw_active_out,
  // Second channel
  input wire logic              ch2_conv_start_in,
  input wire logic [EXP_W-1:0]  ch2_exposure_in,
  input wire logic [CODE_W-1:0] ch2_auto_code_in,
  input wire logic [CODE_W-1:0] ch2_dac_code_out,
  input wire logic              ch2_sw_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_bus_zero_wait: assert property (
    hresp_out == HRESP_OKAY && hreadyout_out)
    else $error("bus answer not okay or not ready");
  a_rdata_bit6_zero: assert property (
    hrdata_out[31:8] == 24'h000000 && !hrdata_out[6])
    else $error("read data has unused bits set");
  a_ch1_unserved_exp: assert property (
    ch1_conv_start_in && ch1_exposure_in != CH1_FIRST_EXP |=>
      !ch1_sw_active_out && ch1_dac_code_out == $past(ch1_auto_code_in))
    else $error("ch1 unserved exposure did not use the on-chip code");
  a_ch1_auto_code: assert property (
    ch1_conv_start_in ##1 !ch1_sw_active_out |->
      ch1_dac_code_out == $past(ch1_auto_code_in))
    else $error("ch1 inactive override but code not on-chip");
  a_ch1_code_holds: assert property (
    !ch1_conv_start_in |=>
      $stable(ch1_dac_code_out) && $stable(ch1_sw_active_out))
    else $error("ch1 code changed without a conversion");
  a_ch1_active_cause: assert property (
    $rose(ch1_sw_active_out) |->
      $past(ch1_conv_start_in) && $past(ch1_exposure_in) == CH1_FIRST_EXP)
    else $error("ch1 software code applied without exposure 6 start");
  a_ch2_unserved_exp: assert property (
    ch2_conv_start_in && !(ch2_exposure_in inside {[1:5]}) |=>
      !ch2_sw_active_out && ch2_dac_code_out == $past(ch2_auto_code_in))
    else $error("ch2 unserved exposure did not use the on-chip code");
  a_ch2_auto_code: assert property (
    ch2_conv_start_in ##1 !ch2_sw_active_out |->
      ch2_dac_code_out == $past(ch2_auto_code_in))
    else $error("ch2 inactive override but code not on-chip");
  a_ch2_code_holds: assert property (
    !ch2_conv_start_in |=>
      $stable(ch2_dac_code_out) && $stable(ch2_sw_active_out))
    else $error("ch2 code changed without a conversion");
endmodule : fine_dac_checker

// ===== sim/tb_top.sv
// Self-checking bench of the fine DAC override register bank
`define CHK(nm, e, a) begin total_checks++; \
  if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fine_dac_pkg::*;
  logic              clk_in, arst_n_in, hsel_in, hwrite_in, hreadyout_out;
  logic              hresp_out, ch1_conv_start_in, ch2_conv_start_in;
  logic              ch1_sw_active_out, ch2_sw_active_out, act_q;
  logic [ADDR_W-1:0] haddr_in;
  logic [1:0]        htrans_in;
  logic [2:0]        hsize_in;
  logic [31:0]       hwdata_in, hrdata_out, rd_q;
  logic [EXP_W-1:0]  ch1_exposure_in, ch2_exposure_in;
  logic [CODE_W-1:0] ch1_auto_code_in, ch2_auto_code_in, code_q;
  logic [CODE_W-1:0] ch1_dac_code_out, ch2_dac_code_out;
  int                n_errors, total_checks;

  always #5 clk_in = ~clk_in;

  fine_dac_override_regs i_dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .ch1_conv_start_in(ch1_conv_start_in),
    .ch1_exposure_in(ch1_exposure_in), .ch1_auto_code_in(ch1_auto_code_in),
    .ch1_dac_code_out(ch1_dac_code_out),
    .ch1_sw_active_out(ch1_sw_active_out),
    .ch2_conv_start_in(ch2_conv_start_in),
    .ch2_exposure_in(ch2_exposure_in), .ch2_auto_code_in(ch2_auto_code_in),
    .ch2_dac_code_out(ch2_dac_code_out),
    .ch2_sw_active_out(ch2_sw_active_out));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Ready and data are looked at mid-cycle, so they match the next edge
  task automatic wait_ready();
    int i;
    for (i = 0; i < 16; i++) begin
      @(negedge clk_in);
      rd_q = hrdata_out;
      if (hreadyout_out === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      stop_test();
    end
    @(posedge clk_in);
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] wd);
    hsel_in   <= 1'b1;
    htrans_in <= HTRANS_NONSEQ;
    haddr_in  <= a;
    hwrite_in <= wr;
    hsize_in  <= HSIZE_WORD;
    wait_ready();
    htrans_in <= HTRANS_IDLE;
    hwdata_in <= wd;
    wait_ready();
  endtask : bus

  function automatic logic [ADDR_W-1:0] ba(input logic [IDX_W-1:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction : ba

  task automatic conv(input logic ch2, input logic [EXP_W-1:0] e,
                      input logic [CODE_W-1:0] a);
    if (ch2) begin
      ch2_conv_start_in <= 1'b1;
      ch2_exposure_in   <= e;
      ch2_auto_code_in  <= a;
    end else begin
      ch1_conv_start_in <= 1'b1;
      ch1_exposure_in   <= e;
      ch1_auto_code_in  <= a;
    end
    @(posedge clk_in);
    ch1_conv_start_in <= 1'b0;
    ch2_conv_start_in <= 1'b0;
    @(negedge clk_in);
    code_q = ch2 ? ch2_dac_code_out : ch1_dac_code_out;
    act_q  = ch2 ? ch2_sw_active_out : ch1_sw_active_out;
    @(posedge clk_in);
  endtask : conv

  task automatic t_reset();
    for (int i = 0; i < NUM_REGS; i++) begin
      bus(1'b0, ba(REG_IDX[i]), 32'h0);
      `CHK("reset value", 32'(REG_RESET), rd_q)
    end
    $display("test reset done");
  endtask : t_reset

  // Bit 6 and the upper bus bits are set on purpose in every write
  task automatic t_readback();
    logic [31:0] exp_v;
    for (int i = 0; i < NUM_REGS; i++)
      bus(1'b1, ba(REG_IDX[i]), 32'hA5A5A540 | 32'(i * 8'h25));
    for (int i = 0; i < NUM_REGS; i++) begin
      bus(1'b0, ba(REG_IDX[i]), 32'h0);
      exp_v = 32'(8'h40 | 8'(i * 8'h25)) & 32'h0BF;
      `CHK("readback", exp_v, rd_q)
    end
    $display("test readback done");
  endtask : t_readback

  task automatic t_refused();
    bus(1'b1, ba(8'h37), 32'hFF);
    bus(1'b0, ba(8'h37), 32'h0);
    `CHK("unmapped read", 32'h0, rd_q)
    bus(1'b1, ba(IDX_CH1_EXP6) | 32'h1, 32'h3F);
    bus(1'b0, ba(IDX_CH1_EXP6), 32'h0);
    `CHK("misaligned write", 32'h0, rd_q)
    $display("test refused done");
  endtask : t_refused

  task automatic t_ch1();
    bus(1'b1, ba(IDX_CH1_EXP6), 32'hAA);
    conv(1'b0, 3'h6, 6'h11);
    `CHK("ch1 sw code", 6'h2A, code_q)
    `CHK("ch1 sw active", 1'b1, act_q)
    bus(1'b0, ba(IDX_CH1_APPLIED), 32'h0);
    `CHK("ch1 applied", 32'hAA, rd_q)
    conv(1'b0, 3'h5, 6'h12);
    `CHK("ch1 other exp", 6'h12, code_q)
    bus(1'b1, ba(IDX_CH1_EXP6), 32'h2A);
    conv(1'b0, 3'h6, 6'h13);
    `CHK("ch1 ovr off code", 6'h13, code_q)
    `CHK("ch1 ovr off active", 1'b0, act_q)
    bus(1'b0, ba(IDX_CH1_APPLIED), 32'h0);
    `CHK("ch1 applied off", 32'h13, rd_q)
    $display("test ch1 done");
  endtask : t_ch1

  task automatic t_ch2();
    for (int e = 1; e <= CH2_NUM_EXP; e++)
      bus(1'b1, ba(REG_IDX[e]), 32'h80 | 32'(e * 7));
    for (int e = 1; e <= CH2_NUM_EXP; e++) begin
      conv(1'b1, EXP_W'(e), 6'h3F);
      `CHK("ch2 sw code", CODE_W'(e * 7), code_q)
      `CHK("ch2 sw active", 1'b1, act_q)
    end
    bus(1'b0, ba(IDX_CH2_APPLIED), 32'h0);
    `CHK("ch2 applied", 32'hA3, rd_q)
    conv(1'b1, 3'h6, 6'h21);
    `CHK("ch2 exp6 code", 6'h21, code_q)
    bus(1'b1, ba(IDX_CH2_EXP3), 32'h15);
    conv(1'b1, 3'h3, 6'h30);
    `CHK("ch2 ovr off code", 6'h30, code_q)
    `CHK("ch2 ovr off active", 1'b0, act_q)
    bus(1'b0, ba(IDX_CH2_APPLIED), 32'h0);
    `CHK("ch2 applied off", 32'h30, rd_q)
    $display("test ch2 done");
  endtask : t_ch2

  initial begin
    clk_in = 1'b0;
    arst_n_in = 1'b0;
    {hsel_in, hwrite_in, ch1_conv_start_in, ch2_conv_start_in} = 4'h0;
    haddr_in = '0;
    htrans_in = HTRANS_IDLE;
    hsize_in = HSIZE_WORD;
    hwdata_in = '0;
    {ch1_exposure_in, ch2_exposure_in} = '0;
    {ch1_auto_code_in, ch2_auto_code_in} = '0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_readback();
    t_refused();
    t_ch1();
    t_ch2();
    stop_test();
  end
endmodule : tb_top

bind fine_dac_override_regs fine_dac_checker i_chk (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .ch1_conv_start_in(ch1_conv_start_in), .ch1_exposure_in(ch1_exposure_in),
  .ch1_auto_code_in(ch1_auto_code_in), .ch1_dac_code_out(ch1_dac_code_out),
  .ch1_sw_active_out(ch1_sw_active_out),
  .ch2_conv_start_in(ch2_conv_start_in), .ch2_exposure_in(ch2_exposure_in),
  .ch2_auto_code_in(ch2_auto_code_in), .ch2_dac_code_out(ch2_dac_code_out),
  .ch2_sw_active_out(ch2_sw_active_out));
